// *** rtl/csi_interp.sv ***
/*
  Control space interpreter: fetches three-word instructions from the
  parallel space and carries them out, with an APB register slave.
  Assumes pio_status and pio_vector are synchronous to pclk and that the
  parallel space answers every request with a one-cycle sp_ack.
*/
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// How it works
// R1 - Host reaches device registers only indirectly
// R2 - Read status, mask requests, disable interrupts
// R3 - No control write: restore saved control
// R4 - Control write goes to shadow until end
// R5 - Pending interrupt: read vector before commands
// R6 - Device End at end, attention if pending
// R7 - Accumulator holds latest register read
// R8 - Index zeroed at entry, step or jump
// R9 - Count over limit: stop, unit check
// R10 - Limit defaults 5000, zero disables, opcode 10
// R11 - Opcode 0 ends interpretation
// R12 - Opcode 2 stores status to target, accumulator
// R13 - Opcode 3 word, opcode 11 byte immediate
// R14 - Opcode 4 moves source to target, accumulator
// R15 - Opcode 5 jumps when masked accumulator zero
// R16 - Opcode 6 jumps when masked bits all set
// R17 - Opcode 7 jumps, opcode 9 on equal
// R18 - Opcode 8 stores vector to target, accumulator
// R19 - Opcode 12 loads accumulator only
// R20 - Opcode 13 selects word or byte mode
// R21 - Opcode 14 attention, data to sense bytes
// R22 - All-ones upper half gives start offset
// R23 - Unknown opcode: stop with unit check
module csi_interp
  import csi_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parallel space
  output csi_sp_req_t sp,
  input wire logic sp_ack,
  input wire logic [15:0] sp_rdata,
  // Parallel control, status and vector
  output logic pio_ctl_we,
  output logic [15:0] pio_ctl_wdata,
  input wire logic [15:0] pio_status,
  input wire logic [15:0] pio_vector,
  output logic pio_vec_ack,
  // Host channel
  output csi_host_t host,
  output logic [15:0] sense_data,
  output logic word_mode,
  output logic busy
);

  csi_regs_t r, n;

  logic acc_setup;
  logic acc_done;
  logic [15:0] cnt_inc;
  logic [15:0] idx_inc;
  logic [15:0] fetch_addr;
  logic lim_hit;

  assign acc_setup = psel && !penable;
  assign acc_done = psel && penable && r.pready;
  assign cnt_inc = r.cnt + 16'h0001;
  assign idx_inc = r.idx + 16'h0001;
  assign fetch_addr = r.base + 16'(r.idx * CSI_JUMP_TARGET_BYTES) + 16'(r.fidx * CSI_WORD_BYTES);
  assign lim_hit = (r.lim != 16'h0000) && (cnt_inc > r.lim);

  always_comb begin
    n = r;
    n.vec_ack = 1'b0;
    n.ctl_we = 1'b0;
    n.host = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // R1 register map has no window onto device space
    if (acc_setup) begin
      n.pready = 1'b1;
      n.prdata = '0;
      case (paddr)
        CSI_OFS_START: n.prdata = '0;
        CSI_OFS_STAT: n.prdata = {28'h000_0000, r.word_mode, r.shadow_vld, r.err, r.st != ST_IDLE};
        CSI_OFS_ACC: n.prdata = {16'h0000, r.acc};
        CSI_OFS_IDX: n.prdata = {16'h0000, r.idx};
        CSI_OFS_CNT: n.prdata = {16'h0000, r.cnt};
        CSI_OFS_LIM: n.prdata = {16'h0000, r.lim};
        CSI_OFS_BASE: n.prdata = {16'h0000, r.base};
        CSI_OFS_SENSE: n.prdata = {16'h0000, r.sense};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (acc_done && pwrite && !r.pslverr) begin
      if (paddr == CSI_OFS_LIM) begin
        n.lim = pwdata[15:0];
      end
      if (paddr == CSI_OFS_BASE) begin
        n.base = pwdata[15:0];
      end
    end

    case (r.st)
      ST_IDLE: begin
        if (acc_done && pwrite && paddr == CSI_OFS_START) begin
          // R22 marked start word carries the offset
          n.idx = (pwdata[31:16] == CSI_START_MARK) ? pwdata[15:0] : 16'h0000;
          n.cnt = '0;
          n.err = 1'b0;
          n.shadow_vld = 1'b0;
          n.fidx = '0;
          n.st = ST_RDSTAT;
        end
      end
      ST_RDSTAT: begin
        // R2 save control image from its status mirror
        n.saved = {CSI_CTL_HI, 1'b1, pio_status[6:0]};
        n.acc = pio_status;
        // R5 release a pending interrupt first
        n.vec_ack = pio_status[CSI_BIT_PEND];
        n.st = ST_SETMASK;
      end
      ST_SETMASK: begin
        // R2 no parallel traffic while interpreting
        n.ctl_we = 1'b1;
        n.ctl_wdata = (r.saved | CSI_CTL_MASKS) & ~(16'h0001 << CSI_BIT_IRQ_EN);
        n.st = ST_FETCH;
      end
      ST_FETCH: begin
        if (!r.sp.req) begin
          n.sp = '{req: 1'b1, we: 1'b0, byte_wr: 1'b0, addr: fetch_addr, wdata: 16'h0000};
        end else if (sp_ack) begin
          n.sp.req = 1'b0;
          case (r.fidx)
            2'd0: n.opc = sp_rdata;
            2'd1: n.op1 = sp_rdata;
            default: n.op2 = sp_rdata;
          endcase
          n.fidx = (r.fidx == 2'd2) ? 2'd0 : r.fidx + 2'd1;
          if (r.fidx == 2'd2) begin
            n.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        n.cnt = cnt_inc;
        n.idx = idx_inc;
        n.st = ST_FETCH;
        // R9 runaway list protection
        if (lim_hit) begin
          n.err = 1'b1;
          n.idx = r.idx;
          n.st = ST_FINISH;
        end else begin
          case (r.opc)
            OP_END: begin
              // R11 terminator
              n.idx = r.idx;
              n.st = ST_FINISH;
            end
            OP_WCTL: begin
              // R4 held back until the run ends
              n.shadow = r.op2;
              n.shadow_vld = 1'b1;
            end
            OP_RSTAT: begin
              // R12 R7 status to target and accumulator
              n.acc = pio_status;
              n.sp = '{req: 1'b1, we: 1'b1, byte_wr: 1'b0, addr: r.op2, wdata: pio_status};
              n.st = ST_DST;
            end
            OP_MOVE_IMM_WORD: begin
              // R13 full word immediate
              n.sp = '{req: 1'b1, we: 1'b1, byte_wr: 1'b0, addr: r.op1, wdata: r.op2};
              n.st = ST_DST;
            end
            OP_MOVE_IMM_BYTE: begin
              // R13 low byte only
              n.sp = '{req: 1'b1, we: 1'b1, byte_wr: 1'b1, addr: r.op1, wdata: {8'h00, r.op2[7:0]}};
              n.st = ST_DST;
            end
            OP_MOVE, OP_LOAD: begin
              n.sp = '{req: 1'b1, we: 1'b0, byte_wr: 1'b0, addr: r.op1, wdata: 16'h0000};
              n.st = ST_SRC;
            end
            OP_TJZ: begin
              // R15 R8 jump on zero under mask
              if ((r.acc & r.op2) == 16'h0000) begin
                n.idx = r.op1;
              end
            end
            OP_TJAS: begin
              // R16 all selected bits set
              if ((r.acc & r.op2) == r.op2) begin
                n.idx = r.op1;
              end
            end
            OP_JUMP: begin
              // R17 unconditional
              n.idx = r.op1;
            end
            OP_COMPARE_JUMP_EQUAL: begin
              // R17 compare equal
              if (r.acc == r.op2) begin
                n.idx = r.op1;
              end
            end
            OP_RVEC: begin
              // R18 R7 vector to target and accumulator
              n.acc = pio_vector;
              n.vec_ack = 1'b1;
              n.sp = '{req: 1'b1, we: 1'b1, byte_wr: 1'b0, addr: r.op2, wdata: pio_vector};
              n.st = ST_DST;
            end
            OP_LIMIT: begin
              // R10 limit from data operand
              n.lim = r.op2;
            end
            OP_WIDTH: begin
              // R20 zero selects byte mode
              n.word_mode = (r.op1 != 16'h0000);
            end
            OP_HOST_ATTENTION_CMD: begin
              // R21 attention with sense data
              n.host.attn = 1'b1;
              n.sense = r.op1;
            end
            default: begin
              // R23 unknown opcode
              n.err = 1'b1;
              n.idx = r.idx;
              n.st = ST_FINISH;
            end
          endcase
        end
      end
      ST_SRC: begin
        if (sp_ack) begin
          // R14 R19 R7 read lands in accumulator
          n.acc = sp_rdata;
          n.sp.req = 1'b0;
          n.st = ST_FETCH;
          if (r.opc == OP_MOVE) begin
            n.sp = '{req: 1'b1, we: 1'b1, byte_wr: 1'b0, addr: r.op2, wdata: sp_rdata};
            n.st = ST_DST;
          end
        end
      end
      ST_DST: begin
        if (sp_ack) begin
          n.sp.req = 1'b0;
          n.sp.we = 1'b0;
          n.st = ST_FETCH;
        end
      end
      ST_FINISH: begin
        // R3 R4 shadow wins, else restore saved image
        n.ctl_we = 1'b1;
        n.ctl_wdata = r.shadow_vld ? r.shadow : r.saved;
        n.st = ST_REPORT;
      end
      ST_REPORT: begin
        // R6 R9 ending status to the host
        n.host.dev_end = 1'b1;
        n.host.unit_check = r.err;
        n.host.attn = pio_status[CSI_BIT_PEND];
        n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.lim <= CSI_LIM_RST;
      r.base <= CSI_BASE_RST;
      r.word_mode <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sp = r.sp;
  assign pio_ctl_we = r.ctl_we;
  assign pio_ctl_wdata = r.ctl_wdata;
  assign pio_vec_ack = r.vec_ack;
  assign host = r.host;
  assign sense_data = r.sense;
  assign word_mode = r.word_mode;
  assign busy = r.busy;

  sequence s_run_ends;
    r.st == ST_FINISH ##1 r.st == ST_REPORT;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    acc_setup |=> pready ##1 !pready) else $error("APB answer not one cycle");

  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    r.st == ST_RDSTAT |=> ##1 pio_ctl_we && pio_ctl_wdata[5:1] == 5'h1F && !pio_ctl_wdata[6])
    else $error("Masks not applied at run start");

  restore_ctl_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    r.st == ST_FINISH && !r.shadow_vld |=> pio_ctl_we && pio_ctl_wdata == $past(r.saved))
    else $error("Saved control not restored");

  shadow_ctl_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    pio_ctl_we |-> $past(r.st) inside {ST_SETMASK, ST_FINISH}) else $error("Control written mid run");

  vector_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    r.st == ST_RDSTAT && pio_status[CSI_BIT_PEND] |=> pio_vec_ack) else $error("Pending vector not read");

  dev_end_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_run_ends |=> host.dev_end && !busy) else $error("Device End missing");

  limit_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    r.st == ST_EXEC && r.lim != 16'h0000 && r.cnt >= r.lim |=> r.err ##1 r.st == ST_REPORT)
    else $error("Limit overrun not stopped");

  jump_taken_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
    r.st == ST_EXEC && r.opc == OP_JUMP && !(r.lim != 16'h0000 && cnt_inc > r.lim)
    |=> r.idx == $past(r.op1)) else $error("Jump target not loaded");

  step_index_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    r.st == ST_EXEC && r.opc == OP_MOVE_IMM_WORD && !(r.lim != 16'h0000 && cnt_inc > r.lim)
    |=> r.idx == $past(r.idx) + 16'h0001) else $error("Index did not step");

  bad_opcode_a: assert property (@(posedge pclk) disable iff (!presetn) // R23
    r.st == ST_EXEC && r.opc > 16'h000E |=> r.err && r.st == ST_FINISH) else $error("Bad opcode ran");

  end_report_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    r.st == ST_REPORT |=> host.dev_end && host.unit_check == $past(r.err)
      && host.attn == $past(pio_status[CSI_BIT_PEND])) else $error("Ending status wrong");

  shadow_out_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    r.st == ST_FINISH && r.shadow_vld |=> pio_ctl_we && pio_ctl_wdata == $past(r.shadow))
    else $error("Shadow control not written at end");

  src_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    r.st == ST_SRC && sp_ack |=> r.acc == $past(sp_rdata))
    else $error("Source read not in accumulator");

  limit_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    r.st == ST_EXEC && r.opc == OP_LIMIT && !lim_hit |=> r.lim == $past(r.op2))
    else $error("Limit not loaded");

  entry_index_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    r.st == ST_IDLE && acc_done && pwrite && paddr == CSI_OFS_START
    |=> r.idx == (($past(pwdata[31:16]) == CSI_START_MARK) ? $past(pwdata[15:0]) : 16'h0000))
    else $error("Start index wrong");

  sp_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    sp.req && !sp_ack |=> sp.req && $stable(sp.addr) && $stable(sp.we) && $stable(sp.wdata))
    else $error("Space request dropped before ack");

  attn_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
    r.st == ST_EXEC && r.opc == OP_HOST_ATTENTION_CMD && !lim_hit |=> host.attn && sense_data == $past(r.op1))
    else $error("Attention command lost");

endmodule

// *** include/csi_pkg.sv ***
/*
  Constants, types and register map of the control space interpreter.
  Assumes a 16-bit parallel space, 32-bit APB and a 40 MHz pclk.
*/
package csi_pkg;

  // APB register byte offsets
  localparam logic [7:0] CSI_OFS_START = 8'h00;
  localparam logic [7:0] CSI_OFS_STAT = 8'h04;
  localparam logic [7:0] CSI_OFS_ACC = 8'h08;
  localparam logic [7:0] CSI_OFS_IDX = 8'h0C;
  localparam logic [7:0] CSI_OFS_CNT = 8'h10;
  localparam logic [7:0] CSI_OFS_LIM = 8'h14;
  localparam logic [7:0] CSI_OFS_BASE = 8'h18;
  localparam logic [7:0] CSI_OFS_SENSE = 8'h1C;

  // Reset values
  localparam logic [15:0] CSI_LIM_RST = 16'h1388;
  localparam logic [15:0] CSI_BASE_RST = 16'h0000;

  // Start word: upper half all ones selects a start offset
  localparam logic [15:0] CSI_START_MARK = 16'hFFFF;

  // Parallel control and status fields
  localparam int CSI_BIT_PEND = 7;
  localparam int CSI_BIT_NOTINIT = 7;
  localparam int CSI_BIT_IRQ_EN = 6;
  localparam logic [15:0] CSI_CTL_MASKS = 16'h003E;
  localparam logic [7:0] CSI_CTL_HI = 8'h3F;

  // Instruction layout: three words, two bytes each
  localparam logic [15:0] CSI_JUMP_TARGET_BYTES = 16'h0006;
  localparam logic [15:0] CSI_WORD_BYTES = 16'h0002;

  typedef enum logic [15:0] {
    OP_END = 16'h0000, OP_WCTL = 16'h0001, OP_RSTAT = 16'h0002, OP_MOVE_IMM_WORD = 16'h0003,
    OP_MOVE = 16'h0004, OP_TJZ = 16'h0005, OP_TJAS = 16'h0006, OP_JUMP = 16'h0007,
    OP_RVEC = 16'h0008, OP_COMPARE_JUMP_EQUAL = 16'h0009, OP_LIMIT = 16'h000A, OP_MOVE_IMM_BYTE = 16'h000B,
    OP_LOAD = 16'h000C, OP_WIDTH = 16'h000D, OP_HOST_ATTENTION_CMD = 16'h000E
  } csi_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_RDSTAT = 4'b0001, ST_SETMASK = 4'b0010, ST_FETCH = 4'b0011,
    ST_EXEC = 4'b0100, ST_SRC = 4'b0101, ST_DST = 4'b0110, ST_FINISH = 4'b0111,
    ST_REPORT = 4'b1000
  } csi_state_t;

  // Request to the parallel space (memory or device registers)
  typedef struct packed {
    logic req;
    logic we;
    logic byte_wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csi_sp_req_t;

  // Reports toward the host channel
  typedef struct packed {
    logic dev_end;
    logic unit_check;
    logic attn;
  } csi_host_t;

  typedef struct packed {
    csi_state_t st;
    logic [1:0] fidx;
    logic [15:0] opc;
    logic [15:0] op1;
    logic [15:0] op2;
    logic [15:0] acc;
    logic [15:0] idx;
    logic [15:0] cnt;
    logic [15:0] lim;
    logic [15:0] base;
    logic [15:0] saved;
    logic [15:0] shadow;
    logic shadow_vld;
    logic err;
    logic word_mode;
    logic [15:0] sense;
    csi_sp_req_t sp;
    logic ctl_we;
    logic [15:0] ctl_wdata;
    logic vec_ack;
    csi_host_t host;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csi_regs_t;

endpackage

// *** sim/csi_space_model.sv ***
/*
  Behavioural model of the parallel space: memory and device registers
  as one word array, answering each request after a settable lag.
  Assumes byte addresses, 16-bit words and one request at a time.
*/
`timescale 1ns/1ps
module csi_space_model
  import csi_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire csi_sp_req_t sp,
  input wire logic [2:0] lag,
  output logic sp_ack,
  output logic [15:0] sp_rdata
);
  logic [15:0] mem [0:32767];
  logic [2:0] wait_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_ack <= 1'b0;
      wait_r <= 3'h0;
      sp_rdata <= 16'h0000;
    end else begin
      sp_ack <= 1'b0;
      // Read data is only valid with the ack, so it toggles otherwise
      sp_rdata <= ~sp_rdata;
      if (sp.req && !sp_ack) begin
        if (wait_r < lag) begin
          wait_r <= wait_r + 3'h1;
        end else begin
          wait_r <= 3'h0;
          sp_ack <= 1'b1;
          if (sp.we && sp.byte_wr) begin
            mem[sp.addr[15:1]][7:0] <= sp.wdata[7:0];
          end else if (sp.we) begin
            mem[sp.addr[15:1]] <= sp.wdata;
          end else begin
            sp_rdata <= mem[sp.addr[15:1]];
          end
        end
      end
    end
  end
endmodule

// *** sim/tb_csi_interp.sv ***
/*
  Self-checking bench of the control space interpreter: APB master,
  instruction lists placed in the space model, checks of each run.
  Assumes the space model answers every request after a random lag.
*/
`timescale 1ns/1ps
module tb_csi_interp
  import csi_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sp_ack, pio_ctl_we, pio_vec_ack, word_mode, busy;
  csi_sp_req_t sp;
  csi_host_t host;
  logic [15:0] sp_rdata, pio_ctl_wdata, sense_data;
  logic [15:0] pio_status = 16'h0000;
  logic [15:0] pio_vector = 16'h0000;
  logic [2:0] lag = 3'h0;
  // Seed 25113
  logic [15:0] lfsr_r = 16'h6219;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] ctl_q[$];
  int vec_n, host_attention_cmd_n, done_n;
  logic end_uc, end_attn;

  always #12.5 pclk = ~pclk;

  csi_interp csi_interp_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sp(sp),
    .sp_ack(sp_ack), .sp_rdata(sp_rdata), .pio_ctl_we(pio_ctl_we), .pio_ctl_wdata(pio_ctl_wdata),
    .pio_status(pio_status), .pio_vector(pio_vector), .pio_vec_ack(pio_vec_ack), .host(host),
    .sense_data(sense_data), .word_mode(word_mode), .busy(busy));
  csi_space_model csi_space_model_i (.pclk(pclk), .presetn(presetn), .sp(sp), .lag(lag), .sp_ack(sp_ack),
    .sp_rdata(sp_rdata));

  always @(posedge pclk) begin
    if (pio_ctl_we) ctl_q.push_back(pio_ctl_wdata);
    if (pio_vec_ack) vec_n++;
    if (host.attn && !host.dev_end) host_attention_cmd_n++;
    if (host.dev_end) begin
      done_n++;
      end_uc = host.unit_check;
      end_attn = host.attn;
    end
  end

  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction

  function automatic logic [15:0] mw(input logic [15:0] a);
    return csi_space_model_i.mem[a[15:1]];
  endfunction

  // Branch list runs five instructions plus each store not jumped over
  function automatic logic [31:0] br_cnt(input logic ne, input logic ns);
    return 32'h0000_0005 + 32'(ne) + 32'(ns);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, exp);
  endtask

  task automatic put(input int i, input logic [15:0] op, input logic [15:0] a, input logic [15:0] b);
    csi_space_model_i.mem[3 * i] = op;
    csi_space_model_i.mem[3 * i + 1] = a;
    csi_space_model_i.mem[3 * i + 2] = b;
  endtask

  task automatic run(input logic [31:0] start);
    int n;
    logic [15:0] t;
    ctl_q.delete();
    vec_n = 0;
    host_attention_cmd_n = 0;
    done_n = 0;
    t = rnd();
    lag <= t[2:0];
    wr(CSI_OFS_START, start);
    n = 0;
    while (done_n == 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    chk("dev_end", done_n, 1);
    chk("busy", busy, 1'b0);
  endtask

  initial begin
    repeat (2000000 / 25) @(posedge pclk);
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] d1, d2, vec, st, msk;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("limit reset", CSI_OFS_LIM, 32'h0000_1388);
    rd_chk("status reset", CSI_OFS_STAT, 32'h0000_0008);
    apb(1'b0, 8'h20, 32'h0000_0000, q, e);
    chk("unmapped", e, 1'b1);
    d1 = rnd() | 16'h0001;
    d2 = rnd();
    vec = rnd();
    st = rnd() & 16'h007F;
    pio_status <= st;
    pio_vector <= vec;
    csi_space_model_i.mem[16'h0801] = 16'hAAAA;
    csi_space_model_i.mem[16'h0803] = 16'h0000;
    put(0, OP_WCTL, 16'h0000, 16'h3FC0);
    put(1, OP_MOVE_IMM_WORD, 16'h1000, d1);
    put(2, OP_MOVE_IMM_BYTE, 16'h1002, d2);
    put(3, OP_MOVE, 16'h1000, 16'h1004);
    put(4, OP_TJZ, 16'h0011, d1);
    put(5, OP_TJZ, 16'h0007, ~d1);
    put(6, OP_MOVE_IMM_WORD, 16'h1006, 16'hDEAD);
    put(7, OP_TJAS, 16'h0009, d1);
    put(8, OP_END, 16'h0000, 16'h0000);
    put(9, OP_RSTAT, 16'h0000, 16'h1008);
    put(10, OP_COMPARE_JUMP_EQUAL, 16'h000C, st);
    put(11, OP_END, 16'h0000, 16'h0000);
    put(12, OP_RVEC, 16'h0000, 16'h100A);
    put(13, OP_LOAD, 16'h1000, 16'h0000);
    put(14, OP_WIDTH, 16'h0000, 16'h0000);
    put(15, OP_HOST_ATTENTION_CMD, 16'h5A5A, 16'h0000);
    put(16, OP_LIMIT, 16'h0000, 16'h0040);
    put(17, OP_END, 16'h0000, 16'h0000);
    run(32'h0000_0000);
    chk("mask write", ctl_q[0], {8'h3F, 8'hBE | {7'h00, st[0]}});
    chk("ctl writes", ctl_q.size(), 2);
    chk("shadow out", ctl_q[ctl_q.size() - 1], 16'h3FC0);
    chk("word imm", mw(16'h1000), d1);
    chk("byte imm", mw(16'h1002), {8'hAA, d2[7:0]});
    chk("move", mw(16'h1004), d1);
    chk("jump skip", mw(16'h1006), 16'h0000);
    chk("status store", mw(16'h1008), st);
    chk("vector store", mw(16'h100A), vec);
    chk("vector reads", vec_n, 1);
    rd_chk("load acc", CSI_OFS_ACC, {16'h0000, d1});
    rd_chk("count", CSI_OFS_CNT, 32'h0000_000F);
    rd_chk("limit op", CSI_OFS_LIM, 32'h0000_0040);
    rd_chk("sense", CSI_OFS_SENSE, 32'h0000_5A5A);
    chk("attn op", host_attention_cmd_n, 1);
    chk("byte mode", word_mode, 1'b0);
    chk("no check", end_uc, 1'b0);
    chk("no attn", end_attn, 1'b0);
    pio_status <= 16'h0085;
    put(20, OP_WIDTH, 16'h0001, 16'h0000);
    put(21, OP_END, 16'h0000, 16'h0000);
    run(32'hFFFF_0014);
    chk("pending vector", vec_n != 0, 1'b1);
    chk("mask pend", ctl_q[0], 16'h3FBF);
    chk("restore", ctl_q[ctl_q.size() - 1], 16'h3F85);
    chk("end attn", end_attn, 1'b1);
    rd_chk("offset count", CSI_OFS_CNT, 32'h0000_0002);
    chk("word mode", word_mode, 1'b1);
    pio_status <= 16'h0000;
    wr(CSI_OFS_LIM, 32'h0000_0003);
    rd_chk("limit rw", CSI_OFS_LIM, 32'h0000_0003);
    put(25, OP_JUMP, 16'h0019, 16'h0000);
    run(32'hFFFF_0019);
    chk("limit stop", end_uc, 1'b1);
    rd_chk("error flag", CSI_OFS_STAT, 32'h0000_000A);
    put(26, 16'h000F, 16'h0000, 16'h0000);
    run(32'hFFFF_001A);
    chk("bad opcode", end_uc, 1'b1);
    wr(CSI_OFS_LIM, 32'h0000_0000);
    put(27, OP_JUMP, 16'h001C, 16'h0000);
    put(28, OP_JUMP, 16'h001D, 16'h0000);
    put(29, OP_JUMP, 16'h001E, 16'h0000);
    put(30, OP_END, 16'h0000, 16'h0000);
    run(32'hFFFF_001B);
    chk("no limit", end_uc, 1'b0);
    rd_chk("jump count", CSI_OFS_CNT, 32'h0000_0004);
    // Random branch list from a moved base, started by an unmarked word
    wr(CSI_OFS_BASE, 32'h0000_0600);
    rd_chk("base rw", CSI_OFS_BASE, 32'h0000_0600);
    repeat (4) begin
      d1 = rnd();
      d2 = rnd();
      msk = rnd();
      if (d2[0]) d2 = d1;
      if (msk[1]) msk = msk & d1;
      csi_space_model_i.mem[16'h0809] = 16'h0000;
      csi_space_model_i.mem[16'h080A] = 16'h0000;
      put(256, OP_MOVE_IMM_WORD, 16'h1010, d1);
      put(257, OP_LOAD, 16'h1010, 16'h0000);
      put(258, OP_COMPARE_JUMP_EQUAL, 16'h0004, d2);
      put(259, OP_MOVE_IMM_WORD, 16'h1012, 16'h0001);
      put(260, OP_TJAS, 16'h0006, msk);
      put(261, OP_MOVE_IMM_WORD, 16'h1014, 16'h0001);
      put(262, OP_END, 16'h0000, 16'h0000);
      run({rnd() & 16'h7FFF, rnd()});
      chk("cmp skip", mw(16'h1012), 16'(d1 != d2));
      chk("all set skip", mw(16'h1014), 16'((d1 & msk) != msk));
      rd_chk("random acc", CSI_OFS_ACC, {16'h0000, d1});
      rd_chk("random count", CSI_OFS_CNT, br_cnt(d1 != d2, (d1 & msk) != msk));
      rd_chk("end index", CSI_OFS_IDX, 32'h0000_0006);
    end
    conclude();
  end
endmodule
